// File: tb/tb_top.sv
// Self-checking testbench of the watchdog control block, one task per scenario.
// Assumes short periods: select 0 times out after 16 cycles, select 3 after 128.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic warm_rst_in = 1'b0;
    logic [3:0] avs_address = 4'h8;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire wdt_irq;
    wire wdt_reset_req;
    int failures = 0;
    int cmp_count = 0;
    int rst_seen = 0;
    logic [31:0] rd;
    wdt_ctrl #(.CNT_W(8), .EXP_BASE(4), .EXP_STEP(1)) wdt_ctrl_inst (.clk_sys, .rstn, .warm_rst_in, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .wdt_irq, .wdt_reset_req);
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (wdt_reset_req === 1'b1)
            rst_seen <= rst_seen + 1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !is_wr;
        avs_write <= is_wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
            check(32'h1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] d);
        bus(1'b1, 4'h8, d, 4'h1);
    endtask
    task automatic rdchk(input logic [7:0] e);
        bus(1'b0, 4'h8, 8'h0, 4'h1);
        check(rd, {24'h0, e});
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (wdt_irq !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, wdt_irq}, 32'h1);
    endtask
    // A count of zero waits the whole span
    task automatic wait_rst(input int lim, input int exp);
        int b;
        int n;
        b = rst_seen;
        n = 0;
        while (rst_seen == b && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(rst_seen - b), 32'(exp));
    endtask
    task automatic porst;
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic t_por;
        porst;
        rdchk(8'hb2);
        bus(1'b0, 4'h4, 8'h0, 4'h1);
        check(rd, 32'h0);
        bus(1'b1, 4'h4, 8'h00, 4'h1);
        bus(1'b1, 4'h8, 8'h00, 4'he);
        rdchk(8'hb2);
    endtask
    // Select 1 times out after 32 cycles: no interrupt may show before that
    task automatic t_fire;
        wr(8'hd3);
        repeat (20) @(posedge clk_sys);
        check({31'h0, wdt_irq}, 32'h0);
        wait_irq(40);
        wait_rst(560, 1);
        rdchk(8'hc6);
        wr(8'h01);
        rdchk(8'h02);
    endtask
    task automatic t_swset;
        wr(8'h73);
        wr(8'h4a);
        wait_irq(10);
        rdchk(8'h7a);
        wait_rst(530, 1);
        rdchk(8'h46);
        check({31'h0, wdt_irq}, 32'h0);
    endtask
    // Clearing the flag alone leaves the reset counter running; restarts keep it from completing
    task automatic t_restart;
        int b;
        wr(8'h73);
        wr(8'h4a);
        wr(8'h40);
        wait_rst(530, 1);
        b = rst_seen;
        wr(8'h4a);
        repeat (50) @(posedge clk_sys);
        repeat (200) wr(8'h63);
        check(32'(rst_seen - b), 32'h0);
        check({31'h0, wdt_irq}, 32'h0);
    endtask
    task automatic t_noreset;
        int b;
        porst;
        wr(8'h41);
        wait_irq(40);
        wait_rst(600, 0);
        rdchk(8'h48);
        wr(8'h08);
        rdchk(8'h08);
        check({31'h0, wdt_irq}, 32'h0);
        wr(8'h73);
        rdchk(8'h70);
        wr(8'h20);
        repeat (300) @(posedge clk_sys);
        rdchk(8'h30);
        b = rst_seen;
        wr(8'h84);
        warm_rst_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        warm_rst_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk(8'h84);
        check(32'(rst_seen - b), 32'h0);
    endtask
    task automatic end_sim;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        failures++;
        end_sim;
    end
    initial
    begin
        t_por;
        t_fire;
        t_swset;
        t_restart;
        t_noreset;
        end_sim;
    end
endmodule // tb_top
`default_nettype wire

// File: tb/wdt_ctrl_sva.sv
// Checker of the watchdog control block, bound to wdt_ctrl.
// Assumes the master holds each request until it samples waitrequest low.
`timescale 1ns/1ps
`default_nettype none
module wdt_ctrl_sva (
    // Clock and resets
    input wire clk_sys,
    input wire rstn,
    input wire warm_rst_in,
    // Register bus
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Watchdog outputs
    input wire wdt_irq,
    input wire wdt_reset_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Cycles since the last landed restart, saturating
    reg [9:0] since_q;
    wire restart_lands = avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_byteenable[0] && avs_writedata[0];
    always @(posedge clk_sys)
    begin
        if (!rstn || restart_lands)
            since_q <= 10'h0;
        else if (since_q != 10'h3ff)
            since_q <= since_q + 10'h1;
    end
    sequence s_mask_lands;
        avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_byteenable[0] && !avs_writedata[6];
    endsequence
    sequence s_irq_gone;
        ##[1:2] !wdt_irq;
    endsequence
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_restart_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[0] == 1'b0 && avs_readdata[31:8] == 24'h0)
        else $error("restart bit or upper bits read nonzero");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != 4'h8 |-> avs_readdata == 32'h0)
        else $error("unmapped read nonzero");
    a_reset_pulse: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("reset request longer than one cycle");
    a_reset_count: assert property (wdt_reset_req |-> since_q >= 10'd512) else $error("reset before 512 cycles");
    a_irq_gate: assert property (s_mask_lands |-> s_irq_gone) else $error("interrupt stays with enable cleared");
    a_por_quiet: assert property (disable iff (1'b0) !rstn |=> !wdt_irq && !wdt_reset_req && avs_waitrequest)
        else $error("outputs active in power-on reset");
endmodule // wdt_ctrl_sva
bind wdt_ctrl wdt_ctrl_sva wdt_ctrl_sva_inst (.clk_sys, .rstn, .warm_rst_in, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .wdt_irq, .wdt_reset_req);
`default_nettype wire

// File: verilog/wdt_ctrl.v
// Watchdog timer control: control register, restart, timeout flag, 512-cycle reset counter.
// Assumes an Avalon-MM master on clk_sys; rstn is the power-on reset, warm_rst_in any other
// reset source arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"

// What this block does
// - Power-on loads B2h; other resets keep bits 7,6,2,1 and clear the rest.
// - Writing one to restart clears the count; restart always reads zero.
// - Reset-enable one lets the watchdog reset the device; zero prevents it.
// - Reset-enable does not affect the interrupt; with interrupt enable clear it decides whether the count runs.
// - Reset-enable set by power-on, kept through other resets.
// - Reset-enable accepts only the first software write.
// - Watchdog reset sets the reset flag; power-on clears it.
// - Software writing one to the reset flag only sets it.
// - Period elapsing sets the timeout interrupt flag.
// - Flag rising starts a 512-cycle reset counter, stopped and cleared by restart.
// - Software setting the flag acts exactly like a hardware timeout.
// - Only restart, a warm reset or the counter completing stops a running reset counter; clearing the flag does not.
// - With flag set, the two enables pick interrupt, reset, both or neither.
// - With flag clear, no interrupt is seen whatever the enables hold.
// - Both enables zero disables the watchdog and freezes the count.
// - Reset counter completing with reset-enable one performs a watchdog reset.
// - Interrupt enable gates the request; power-on clears it, others keep it.
// - Period select takes a write only when the same write sets restart.
// - Changing period select always restarts the count, as it only arrives with restart or a warm reset.
module wdt_ctrl #(
    parameter CNT_W = 24,
    parameter EXP_BASE = 15,
    parameter EXP_STEP = 3
) (
    // Clock and power-on reset
    input wire clk_sys,
    input wire rstn,
    // Other reset sources, asynchronous, active high
    input wire warm_rst_in,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Watchdog outputs
    output reg wdt_irq,
    output reg wdt_reset_req
);

    // Warm reset synchroniser
    reg [2:0] wsync_q;
    reg warm_q;
    wire warm_rst;

    // Power-on value of the control register, split into its fields at reset
    localparam [7:0] CTRL_POR = `WDT_CTRL_POR_VAL;

    // Control register fields
    reg por_flag_q;
    reg por_flag_d;
    reg irq_en_q;
    reg irq_en_d;
    reg [1:0] period_sel_q;
    reg [1:0] period_sel_d;
    reg irq_flag_q;
    reg irq_flag_d;
    reg rst_flag_q;
    reg rst_flag_d;
    reg rst_en_q;
    reg rst_en_d;
    reg rst_en_lock_q;
    reg rst_en_lock_d;

    // Reset counter
    reg rc_run_q;
    reg rc_run_d;
    reg [`WDT_RSTCNT_W-1:0] rc_cnt_q;
    reg [`WDT_RSTCNT_W-1:0] rc_cnt_d;

    // Bus and event terms
    wire hit;
    wire wr_commit;
    wire sw_restart;
    wire timeout_pulse;
    wire wd_fire;
    wire warm_any;
    wire cnt_en;
    wire cnt_clr;
    wire [7:0] ctrl_rd;

    // A change on the warm reset pin counts once the second and third stages agree
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            wsync_q <= 3'h0;
        end
        else
        begin
            wsync_q <= {wsync_q[1:0], warm_rst_in};
        end
    end

    // Holding the last agreed level keeps a one-stage glitch from starting or ending a warm reset
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            warm_q <= 1'b0;
        end
        else if (wsync_q[1] == wsync_q[2])
        begin
            warm_q <= wsync_q[2];
        end
    end

    assign warm_rst = warm_q;

    // Register bus decode; a write takes effect at the edge where waitrequest is seen low
    assign hit = (avs_address == `WDT_REG_CTRL);
    assign wr_commit = avs_write & ~avs_waitrequest & hit & avs_byteenable[0];
    assign sw_restart = wr_commit & avs_writedata[`WDT_BIT_RESTART];

    // Restart reads back as zero
    assign ctrl_rd = {por_flag_q, irq_en_q, period_sel_q, irq_flag_q, rst_flag_q, rst_en_q, 1'b0};

    // Reset counter reaching its last cycle resets the device only with reset-enable set
    assign wd_fire = rc_run_q & (rc_cnt_q == `WDT_RSTCNT_LAST) & rst_en_q & ~sw_restart;
    assign warm_any = warm_rst | wd_fire;

    // Count held when both enables are clear; reset-enable plays no other part here
    assign cnt_en = rst_en_q | irq_en_q;
    // A period change only arrives with restart or a warm reset, both of which clear the count
    assign cnt_clr = sw_restart | warm_any;

    wdt_period_cnt #(
        .CNT_W(CNT_W),
        .EXP_BASE(EXP_BASE),
        .EXP_STEP(EXP_STEP)
    ) u_period (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .cnt_en(cnt_en),
        .cnt_clr(cnt_clr),
        .period_sel(period_sel_q),
        .timeout_pulse(timeout_pulse)
    );

    // Next state of the control register
    always @*
    begin
        por_flag_d = por_flag_q;
        irq_en_d = irq_en_q;
        period_sel_d = period_sel_q;
        irq_flag_d = irq_flag_q;
        rst_flag_d = rst_flag_q;
        rst_en_d = rst_en_q;
        rst_en_lock_d = rst_en_lock_q;
        if (wr_commit)
        begin
            por_flag_d = avs_writedata[`WDT_BIT_POR_FLAG];
            irq_en_d = avs_writedata[`WDT_BIT_IRQ_EN];
            irq_flag_d = avs_writedata[`WDT_BIT_IRQ_FLAG];
            rst_flag_d = avs_writedata[`WDT_BIT_RST_FLAG];
            rst_en_lock_d = 1'b1;
            if (!rst_en_lock_q)
            begin
                rst_en_d = avs_writedata[`WDT_BIT_RST_EN];
            end
            if (avs_writedata[`WDT_BIT_RESTART])
            begin
                period_sel_d = avs_writedata[`WDT_BIT_SEL_HI:`WDT_BIT_SEL_LO];
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (timeout_pulse)
        begin
            irq_flag_d = 1'b1;
        end
        // Any non power-on reset keeps bits 7, 6, 2, 1 and clears the others
        if (warm_any)
        begin
            period_sel_d = 2'h0;
            irq_flag_d = 1'b0;
            por_flag_d = por_flag_q;
            irq_en_d = irq_en_q;
            rst_en_d = rst_en_q;
            rst_flag_d = rst_flag_q;
            rst_en_lock_d = rst_en_lock_q;
        end
        if (wd_fire)
        begin
            rst_flag_d = 1'b1;
        end
    end

    // Reset counter: started by a rising flag, stopped by restart, a warm reset or its last cycle
    always @*
    begin
        rc_run_d = rc_run_q;
        rc_cnt_d = rc_cnt_q;
        if (warm_any || sw_restart)
        begin
            rc_run_d = 1'b0;
            rc_cnt_d = {`WDT_RSTCNT_W{1'b0}};
        end
        else if (rc_run_q)
        begin
            if (rc_cnt_q == `WDT_RSTCNT_LAST)
            begin
                // Counter spent with reset disabled: stop and wait for the next rising flag
                rc_run_d = 1'b0;
                rc_cnt_d = {`WDT_RSTCNT_W{1'b0}};
            end
            else
            begin
                rc_cnt_d = rc_cnt_q + {{(`WDT_RSTCNT_W-1){1'b0}}, 1'b1};
            end
        end
        else if (irq_flag_d && !irq_flag_q)
        begin
            rc_run_d = 1'b1;
            rc_cnt_d = {`WDT_RSTCNT_W{1'b0}};
        end
    end

    // Control state; power-on loads the documented value
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            por_flag_q <= CTRL_POR[`WDT_BIT_POR_FLAG];
            irq_en_q <= CTRL_POR[`WDT_BIT_IRQ_EN];
            period_sel_q <= CTRL_POR[`WDT_BIT_SEL_HI:`WDT_BIT_SEL_LO];
            irq_flag_q <= CTRL_POR[`WDT_BIT_IRQ_FLAG];
            rst_flag_q <= CTRL_POR[`WDT_BIT_RST_FLAG];
            rst_en_q <= CTRL_POR[`WDT_BIT_RST_EN];
            rst_en_lock_q <= 1'b0;
            rc_run_q <= 1'b0;
            rc_cnt_q <= {`WDT_RSTCNT_W{1'b0}};
        end
        else
        begin
            por_flag_q <= por_flag_d;
            irq_en_q <= irq_en_d;
            period_sel_q <= period_sel_d;
            irq_flag_q <= irq_flag_d;
            rst_flag_q <= rst_flag_d;
            rst_en_q <= rst_en_d;
            rst_en_lock_q <= rst_en_lock_d;
            rc_run_q <= rc_run_d;
            rc_cnt_q <= rc_cnt_d;
        end
    end

    // Watchdog outputs, registered
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            wdt_irq <= 1'b0;
            wdt_reset_req <= 1'b0;
        end
        else
        begin
            // Flag clear means no interrupt, whatever the enables hold
            wdt_irq <= irq_flag_d & irq_en_d;
            wdt_reset_req <= wd_fire;
        end
    end

    // Avalon slave: one wait state, waitrequest low for exactly one cycle per request
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else
        begin
            if ((avs_read || avs_write) && avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                if (avs_read && hit)
                begin
                    avs_readdata <= {24'h0, ctrl_rd};
                end
                else
                begin
                    // Unmapped addresses and writes answer with zero
                    avs_readdata <= 32'h0;
                end
            end
            else
            begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

endmodule // wdt_ctrl

`default_nettype wire

// File: verilog/wdt_period_cnt.v
// Watchdog period counter: counts while enabled, pulses at the selected period.
// Assumes the enable, clear and select come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module wdt_period_cnt #(
    parameter CNT_W = 24,
    parameter EXP_BASE = 15,
    parameter EXP_STEP = 3
) (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Control
    input wire cnt_en,
    input wire cnt_clr,
    input wire [1:0] period_sel,
    // Status
    output wire timeout_pulse
);

    reg [CNT_W-1:0] cnt_q;
    reg [CNT_W-1:0] cnt_d;
    wire [CNT_W-1:0] lim [0:3];

    // Period of setting g is 2 to the power EXP_BASE + g*EXP_STEP cycles
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_lim
            assign lim[g] = {CNT_W{1'b1}} >> (CNT_W - (EXP_BASE + EXP_STEP * g));
        end
    endgenerate

    assign timeout_pulse = cnt_en & ~cnt_clr & (cnt_q == lim[period_sel]);

    always @*
    begin
        cnt_d = cnt_q;
        if (cnt_clr)
        begin
            cnt_d = {CNT_W{1'b0}};
        end
        else if (timeout_pulse)
        begin
            cnt_d = {CNT_W{1'b0}};
        end
        else if (cnt_en)
        begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cnt_q <= {CNT_W{1'b0}};
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule // wdt_period_cnt

`default_nettype wire

// File: verilog/wdt_regs.vh
// Register map, field positions, reset values and timing counts of the watchdog control block.
// Assumes byte addressing on the register bus, one 32-bit word per register.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Register offsets (byte addresses)
`define WDT_REG_CTRL 4'h8

// Field positions of watchdog_control
`define WDT_BIT_RESTART 0
`define WDT_BIT_RST_EN 1
`define WDT_BIT_RST_FLAG 2
`define WDT_BIT_IRQ_FLAG 3
`define WDT_BIT_SEL_LO 4
`define WDT_BIT_SEL_HI 5
`define WDT_BIT_IRQ_EN 6
`define WDT_BIT_POR_FLAG 7

// Reset values
`define WDT_CTRL_POR_VAL 8'hb2
`define WDT_CTRL_WARM_KEEP 8'hc6

// Reset counter length in clock cycles, and its counter width
`define WDT_RST_CYCLES 512
`define WDT_RSTCNT_W 10
`define WDT_RSTCNT_LAST 10'h1ff

`endif
